// >>> lao_level_arb.sv
// Level input arbitration, analog output drive and register file
//
// Overview of operation
// - Input below minimum or above 21 mA faulted
// - Valid input interpolated linearly to an elevation
// - Dual inputs: lower-numbered input is primary
// - Primary up to 19.8 mA used alone
// - Primary low: secondary used up to 20 mA
// - Both low: no level, flowmeter failed
// - Primary above 19.8: take greater level
// - Primary above 19.8, secondary rejected: primary
// - Fault drives 4 mA, holds, or zero
// - Under-range 4 mA, over-range 20 mA
// - Outside measurement mode outputs hold value
`timescale 1ns/1ps
module lao_level_arb #(
    parameter int NUM_OUT    = 4,
    parameter int CYCLE_CLKS = lao_pkg::MEAS_CYCLE_CLKS
) (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire lao_pkg::lao_bus_t      bus,
    output logic [31:0]                 rdata,
    input  wire logic [15:0]            cur1,
    input  wire logic [15:0]            cur2,
    input  wire logic [NUM_OUT*16-1:0]  outValues,
    input  wire logic [NUM_OUT-1:0]     outFaults,
    output lao_pkg::lao_lvl_t           sectionLevel,
    output logic                        flowFailed,
    output logic [NUM_OUT*16-1:0]       outCodes,
    output logic                        irq
);
    // ****************************************
    // Parameter checks
    // ****************************************
    if (NUM_OUT < 1 || NUM_OUT > 8)
        $error("NUM_OUT must be 1 to 8");
    if (CYCLE_CLKS < 2)
        $error("CYCLE_CLKS must be at least 2");

    // True when addr selects range register i, high end if hiSel
    function automatic logic rangeSel(input logic [7:0] addr,
                                      input int i, input logic hiSel);
        logic [7:0] base;
        base = lao_pkg::ADDR_RANGE + 8'(i) * lao_pkg::RANGE_STRIDE;
        rangeSel = addr == (base + (hiSel ? lao_pkg::RANGE_HI_OFS
                                          : 8'h00));
    endfunction

    // ****************************************
    // Measurement cycle divider
    // ****************************************
    logic [31:0] divCnt;
    logic [31:0] next_divCnt;
    logic        tick;

    // Free running so cycle phase is independent of mode changes
    always_comb
    begin
        tick = divCnt == 32'(CYCLE_CLKS - 1);
        next_divCnt = tick ? 32'h0000_0000 : divCnt + 32'h0000_0001;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            divCnt <= 32'h0000_0000;
        else
            divCnt <= next_divCnt;
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [1:0]        ctrl;
    logic [15:0]       minValid;
    logic [15:0]       low1, high1, low2, high2;
    logic [lao_pkg::ST_W-1:0] status, mask;
    logic [2*NUM_OUT-1:0]     fmode;
    logic [15:0]       rangeLo [NUM_OUT];
    logic [15:0]       rangeHi [NUM_OUT];
    logic [1:0]        next_ctrl;
    logic [15:0]       next_minValid;
    logic [15:0]       next_low1, next_high1, next_low2, next_high2;
    logic [lao_pkg::ST_W-1:0] next_status, next_mask, events;
    logic [2*NUM_OUT-1:0]     next_fmode;
    logic [15:0]       next_rangeLo [NUM_OUT];
    logic [15:0]       next_rangeHi [NUM_OUT];
    logic [31:0]       next_rdata;
    logic              measure, dual, sample;

    assign measure = ctrl[lao_pkg::CTRL_MEASURE];
    assign dual    = ctrl[lao_pkg::CTRL_DUAL];
    assign sample  = tick && measure;

    // Write decode; status clears by writing ones, events win
    always_comb
    begin
        logic wr;
        wr = bus.wr;
        next_ctrl     = ctrl;
        next_minValid = minValid;
        next_low1     = low1;
        next_high1    = high1;
        next_low2     = low2;
        next_high2    = high2;
        next_mask     = mask;
        next_fmode    = fmode;
        next_status   = status;
        if (wr)
        begin
            case (bus.addr)
                lao_pkg::ADDR_CTRL:     next_ctrl = bus.wdata[1:0];
                lao_pkg::ADDR_MINVALID: next_minValid = bus.wdata[15:0];
                lao_pkg::ADDR_LOW1:     next_low1 = bus.wdata[15:0];
                lao_pkg::ADDR_HIGH1:    next_high1 = bus.wdata[15:0];
                lao_pkg::ADDR_LOW2:     next_low2 = bus.wdata[15:0];
                lao_pkg::ADDR_HIGH2:    next_high2 = bus.wdata[15:0];
                lao_pkg::ADDR_MASK:
                    next_mask = bus.wdata[lao_pkg::ST_W-1:0];
                lao_pkg::ADDR_FMODE:
                    next_fmode = bus.wdata[2*NUM_OUT-1:0];
                lao_pkg::ADDR_STATUS:
                    next_status = status & ~bus.wdata[lao_pkg::ST_W-1:0];
                default: ;
            endcase
        end
        next_status = next_status | events;
        for (int i = 0; i < NUM_OUT; i++)
        begin
            next_rangeLo[i] = (wr && rangeSel(bus.addr, i, 1'b0))
                              ? bus.wdata[15:0] : rangeLo[i];
            next_rangeHi[i] = (wr && rangeSel(bus.addr, i, 1'b1))
                              ? bus.wdata[15:0] : rangeHi[i];
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (bus.rd)
        begin
            case (bus.addr)
                lao_pkg::ADDR_CTRL:     next_rdata = 32'(ctrl);
                lao_pkg::ADDR_MINVALID: next_rdata = 32'(minValid);
                lao_pkg::ADDR_LOW1:     next_rdata = 32'(low1);
                lao_pkg::ADDR_HIGH1:    next_rdata = 32'(high1);
                lao_pkg::ADDR_LOW2:     next_rdata = 32'(low2);
                lao_pkg::ADDR_HIGH2:    next_rdata = 32'(high2);
                lao_pkg::ADDR_STATUS:   next_rdata = 32'(status);
                lao_pkg::ADDR_MASK:     next_rdata = 32'(mask);
                lao_pkg::ADDR_LEVEL:    next_rdata = 32'(sectionLevel);
                lao_pkg::ADDR_FMODE:    next_rdata = 32'(fmode);
                default: ;
            endcase
            for (int i = 0; i < NUM_OUT; i++)
            begin
                if (rangeSel(bus.addr, i, 1'b0))
                    next_rdata = 32'(rangeLo[i]);
                if (rangeSel(bus.addr, i, 1'b1))
                    next_rdata = 32'(rangeHi[i]);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl     <= lao_pkg::RST_CTRL;
            minValid <= lao_pkg::RST_MINVALID;
            low1     <= lao_pkg::RST_LOW;
            high1    <= lao_pkg::RST_HIGH;
            low2     <= lao_pkg::RST_LOW;
            high2    <= lao_pkg::RST_HIGH;
            status   <= '0;
            mask     <= '0;
            fmode    <= '0;
            rdata    <= 32'h0000_0000;
            for (int i = 0; i < NUM_OUT; i++)
            begin
                rangeLo[i] <= lao_pkg::RST_LOW;
                rangeHi[i] <= lao_pkg::RST_RANGE_HI;
            end
        end
        else
        begin
            ctrl     <= next_ctrl;
            minValid <= next_minValid;
            low1     <= next_low1;
            high1    <= next_high1;
            low2     <= next_low2;
            high2    <= next_high2;
            status   <= next_status;
            mask     <= next_mask;
            fmode    <= next_fmode;
            rdata    <= next_rdata;
            rangeLo  <= next_rangeLo;
            rangeHi  <= next_rangeHi;
        end
    end

    // Level output interrupt, high while any unmasked flag stands
    assign irq = |(status & mask);

    // ****************************************
    // Level inputs and arbitration
    // ****************************************
    lao_pkg::lao_lvl_t s1, s2, next_level;
    logic              flt1, flt2, next_failed;

    lao_level_scale u_scale1 (
        .curUa    (cur1),
        .minValid (minValid),
        .lowElev  (low1),
        .highElev (high1),
        .scaled   (s1),
        .fault    (flt1)
    );

    lao_level_scale u_scale2 (
        .curUa    (cur2),
        .minValid (minValid),
        .lowElev  (low2),
        .highElev (high2),
        .scaled   (s2),
        .fault    (flt2)
    );

    // A faulted input counts as rejected, including above 21 mA
    always_comb
    begin
        next_level = sectionLevel;
        next_failed = flowFailed;
        events = '0;
        if (sample)
        begin
            events[lao_pkg::ST_CYCLE] = 1'b1;
            events[lao_pkg::ST_FLT1]  = flt1;
            events[lao_pkg::ST_FLT2]  = flt2 && dual;
            if (!dual)
                next_level = s1;
            else if (!flt1 && cur1 <= lao_pkg::UA_PRIM_HI)
                next_level = s1;
            else if (flt1)
            begin
                next_level.elev  = s2.elev;
                next_level.valid = !flt2 && cur2 <= lao_pkg::UA_SEC_HI;
            end
            else if (!flt2 && s2.elev > s1.elev)
                next_level = s2;
            else
                next_level = s1;
            next_failed = !next_level.valid;
            events[lao_pkg::ST_NOLEVEL] = !next_level.valid;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sectionLevel <= '0;
            flowFailed   <= 1'b0;
        end
        else
        begin
            sectionLevel <= next_level;
            flowFailed   <= next_failed;
        end
    end

    a_primary_used: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample && dual && !flt1 && cur1 <= lao_pkg::UA_PRIM_HI
        |=> sectionLevel == $past(s1))
        else $error("primary in range not used");
    a_secondary_used: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample && dual && flt1 && !flt2 && cur2 <= lao_pkg::UA_SEC_HI
        |=> sectionLevel.valid && sectionLevel.elev == $past(s2.elev))
        else $error("secondary not taken");
    a_both_rejected: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample && dual && flt1 && flt2
        |=> flowFailed && !sectionLevel.valid)
        else $error("failure not declared");
    a_greater_taken: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample && dual && !flt1 && cur1 > lao_pkg::UA_PRIM_HI && !flt2
        |=> sectionLevel.elev >= $past(s1.elev)
            && sectionLevel.elev >= $past(s2.elev))
        else $error("greater level not taken");
    a_primary_alone: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample && dual && !flt1 && cur1 > lao_pkg::UA_PRIM_HI && flt2
        |=> sectionLevel == $past(s1))
        else $error("primary not used alone");
    a_fault_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample && cur1 > lao_pkg::UA_FAULT_HI
        |=> status[lao_pkg::ST_FLT1])
        else $error("over-current fault not flagged");
    a_cycle_update: assert property (@(posedge clk_sys) disable iff (!nrst)
        !sample |=> $stable(sectionLevel) && $stable(flowFailed))
        else $error("level changed between cycles");

    // ****************************************
    // Analog outputs
    // ****************************************
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : gOut
        logic [15:0] target;
        logic [15:0] code;
        logic [15:0] next_code;
        logic signed [15:0] val;

        assign val = outValues[g*16 +: 16];

        lao_out_scale u_out (
            .value   (val),
            .rangeLo (rangeLo[g]),
            .rangeHi (rangeHi[g]),
            .fault   (outFaults[g]),
            .mode    (lao_pkg::lao_fmode_t'(fmode[2*g +: 2])),
            .held    (code),
            .code    (target)
        );

        // Leaving measurement mode freezes the last driven code
        assign next_code = sample ? target : code;

        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
                code <= lao_pkg::UA_4MA;
            else
                code <= next_code;
        end

        assign outCodes[g*16 +: 16] = code;

        a_idle_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
            !measure |=> $stable(code))
            else $error("output moved outside measurement");
        a_under_range: assert property (@(posedge clk_sys) disable iff (!nrst)
            sample && !outFaults[g] && $signed(val) < $signed(rangeLo[g])
            |=> code == lao_pkg::UA_4MA)
            else $error("under-range not 4 mA");
        a_fault_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
            sample && outFaults[g] && fmode[2*g +: 2] == 2'h1
            |=> $stable(code))
            else $error("fault hold lost value");
    end
endmodule

// >>> lao_level_arb_tb.sv
// Self-checking testbench of the level arbitration and output block
`timescale 1ns/1ps
module lao_level_arb_tb;
    logic                clk_sys;
    logic                nrst;
    lao_pkg::lao_bus_t   bus;
    logic [31:0]         rdata;
    logic [15:0]         want1;
    logic [15:0]         want2;
    logic [15:0]         cur1;
    logic [15:0]         cur2;
    logic [15:0]         outValues;
    logic                outFaults;
    lao_pkg::lao_lvl_t   sectionLevel;
    logic                flowFailed;
    logic [15:0]         outCodes;
    logic                irq;
    logic [2:0]          divCnt;
    logic                rdSeen;
    logic [31:0]         rdQ[$];
    logic [33:0]         msQ[$];
    logic [33:0]         lastExp;
    logic [1:0]          fm;
    logic                single;
    int                  num_errors;
    int                  samples_checked;
    int                  seed;
    int                  lastCode;
    int                  rlo;
    int                  rhi;

    // ****************************************
    // Clock, partner and device
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    lao_loop_model LOOPS (.clk_sys(clk_sys), .want1(want1), .want2(want2),
                          .cur1(cur1), .cur2(cur2));

    lao_level_arb #(.NUM_OUT(1), .CYCLE_CLKS(8)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata),
        .cur1(cur1), .cur2(cur2), .outValues(outValues),
        .outFaults(outFaults), .sectionLevel(sectionLevel),
        .flowFailed(flowFailed), .outCodes(outCodes), .irq(irq));

    // Mirror of the measurement divider; tick when it reads 7
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            divCnt <= 3'h0;
            rdSeen <= 1'b0;
        end
        else
        begin
            divCnt <= divCnt + 3'h1;
            rdSeen <= bus.rd;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic bus_op(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        bus <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        bus_op(1'b0, a, 32'h0000_0000);
    endtask

    function automatic int elev(input int c, input int lo, input int hi);
        return lo + (c - 4000) * (hi - lo) / 16000;
    endfunction

    // Inputs change just after a tick, so the next tick samples them
    task automatic meas(input int c1, input int c2, input int v,
                        input logic f);
        int   e1;
        int   e2;
        logic ok1;
        logic ok2;
        logic [15:0] el;
        e1 = elev(c1, 0, 1000);
        e2 = elev(c2, 0, 2000);
        ok1 = c1 >= 3600 && c1 <= 21000;
        ok2 = !single && c2 >= 3600 && c2 <= 20000;
        el = (ok1 && (c1 <= 19800 || !ok2 || e1 >= e2)) ? e1 : e2;
        // Single input mode reports input 1 alone, valid while unfaulted
        if (single)
            el = e1;
        if (f)
            lastCode = fm == 2'h1 ? lastCode : fm == 2'h2 ? 0 : 4000;
        else if (v <= rlo || v >= rhi)
            lastCode = v <= rlo ? 4000 : 20000;
        else
            lastCode = 4000 + (v - rlo) * 16000 / (rhi - rlo);
        lastExp = {!(ok1 || ok2), ok1 || ok2, el, lastCode[15:0]};
        do @(negedge clk_sys); while (divCnt != 3'h0);
        @(posedge clk_sys);
        want1 <= c1[15:0];
        want2 <= c2[15:0];
        outValues <= v[15:0];
        outFaults <= f;
        msQ.push_back(lastExp);
        while (msQ.size() != 0)
            @(negedge clk_sys);
    endtask

    task automatic end_of_test();
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // Monitor: oldest note against each result
    // ****************************************
    always @(negedge clk_sys)
    begin
        if (rdSeen && rdQ.size() > 0)
            check(rdata === rdQ.pop_front(), "register read");
        if (divCnt == 3'h0 && msQ.size() > 0)
            check({flowFailed, sectionLevel, outCodes} === msQ.pop_front(),
                  "measurement result");
    end

    // Watchdog; the run needs well under 2000 cycles
    initial
    begin
        #(40 * 5000);
        num_errors++;
        end_of_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        seed = 37284;
        nrst = 1'b0;
        bus = '0;
        want1 = 16'h0FA0;
        want2 = 16'h0FA0;
        outValues = 16'h0000;
        outFaults = 1'b0;
        fm = 2'h0;
        single = 1'b0;
        lastCode = 4000;
        rlo = 0;
        rhi = 10000;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        check(outCodes === 16'h0FA0 && sectionLevel === '0 &&
              flowFailed === 1'b0 && irq === 1'b0, "reset values");
        rd_chk(lao_pkg::ADDR_MINVALID, 32'h0000_0E10);
        rd_chk(lao_pkg::ADDR_HIGH1, 32'h0000_03E8);
        rd_chk(lao_pkg::ADDR_RANGE + lao_pkg::RANGE_HI_OFS, 32'h0000_2710);
        rd_chk(8'h3C, 32'h0000_0000);
        bus_op(1'b1, lao_pkg::ADDR_HIGH2, 32'h0000_07D0);
        bus_op(1'b1, lao_pkg::ADDR_CTRL, 32'h0000_0003);
        meas(12000, 5000, 5000, 1'b0);
        meas(3599, 12000, -10, 1'b0);
        meas(3600, 3599, 20000, 1'b0);
        meas(3599, 3599, 100, 1'b0);
        meas(20000, 15000, 9999, 1'b0);
        meas(19801, 4000, 1, 1'b0);
        meas(20000, 3000, 7000, 1'b0);
        meas(21001, 12000, 7000, 1'b0);
        for (int m = 0; m < 3; m++)
        begin
            fm = m[1:0];
            bus_op(1'b1, lao_pkg::ADDR_FMODE, m);
            meas(12000, 5000, 2500 + m, 1'b0);
            meas(12000, 5000, 7000, 1'b1);
        end
        rlo = -5000;
        rhi = 5000;
        bus_op(1'b1, lao_pkg::ADDR_RANGE, 32'h0000_EC78);
        bus_op(1'b1, lao_pkg::ADDR_RANGE + lao_pkg::RANGE_HI_OFS,
               32'h0000_1388);
        meas(8000, 5000, 0, 1'b0);
        for (int i = 0; i < 8; i++)
            meas(3000 + {$random(seed)} % 19000,
                 3000 + {$random(seed)} % 17001,
                 $random(seed) % 12000, 1'b0);
        single = 1'b1;
        bus_op(1'b1, lao_pkg::ADDR_CTRL, 32'h0000_0001);
        meas(3599, 12000, 100, 1'b0);
        meas(20500, 3000, 4000, 1'b0);
        single = 1'b0;
        bus_op(1'b1, lao_pkg::ADDR_CTRL, 32'h0000_0003);
        meas(3000, 3000, -7000, 1'b0);
        bus_op(1'b1, lao_pkg::ADDR_CTRL, 32'h0000_0002);
        want1 <= 16'h2EE0;
        want2 <= 16'h2EE0;
        outValues <= 16'h0100;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        check({flowFailed, sectionLevel, outCodes} === lastExp,
              "held outputs");
        check(irq === 1'b0, "masked interrupt");
        rd_chk(lao_pkg::ADDR_STATUS, 32'h0000_000F);
        bus_op(1'b1, lao_pkg::ADDR_MASK, 32'h0000_0004);
        @(negedge clk_sys);
        check(irq === 1'b1, "interrupt raised");
        bus_op(1'b1, lao_pkg::ADDR_STATUS, 32'h0000_0004);
        @(negedge clk_sys);
        check(irq === 1'b0, "interrupt cleared");
        rd_chk(lao_pkg::ADDR_STATUS, 32'h0000_000B);
        repeat (3) @(posedge clk_sys);
        end_of_test();
    end
endmodule

// >>> lao_level_scale.sv
// Fault check and elevation scaling of one level input
`timescale 1ns/1ps
module lao_level_scale (
    input  wire logic [15:0]        curUa,
    input  wire logic [15:0]        minValid,
    input  wire logic signed [15:0] lowElev,
    input  wire logic signed [15:0] highElev,
    output lao_pkg::lao_lvl_t       scaled,
    output logic                    fault
);
    logic signed [16:0] diff;
    logic signed [16:0] span;
    logic signed [33:0] prod;
    logic signed [33:0] quot;

    // Interpolate over 4..20 mA; 20..21 mA extrapolates past high end
    always_comb
    begin
        diff = $signed({1'b0, curUa}) - $signed({1'b0, lao_pkg::UA_4MA});
        span = {highElev[15], highElev} - {lowElev[15], lowElev};
        prod = 34'(diff) * 34'(span);
        quot = prod / $signed({18'h0_0000, lao_pkg::UA_SPAN});
        scaled.elev  = lowElev + quot[15:0];
        fault = (curUa < minValid) || (curUa > lao_pkg::UA_FAULT_HI);
        scaled.valid = !fault;
    end
endmodule

// >>> lao_loop_model.sv
// Behavioural model of the two current-loop level sensors
`timescale 1ns/1ps
module lao_loop_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] want1,
    input  wire logic [15:0] want2,
    output logic      [15:0] cur1,
    output logic      [15:0] cur2
);
    // Loop current settles one clock after a new demand, like a real
    // transmitter it never changes in the same step as the request
    always_ff @(posedge clk_sys)
    begin
        cur1 <= want1;
        cur2 <= want2;
    end
endmodule

// >>> lao_out_scale.sv
// Target current code of one analog output
`timescale 1ns/1ps
module lao_out_scale (
    input  wire logic signed [15:0] value,
    input  wire logic signed [15:0] rangeLo,
    input  wire logic signed [15:0] rangeHi,
    input  wire logic               fault,
    input  wire lao_pkg::lao_fmode_t mode,
    input  wire logic [15:0]        held,
    output logic [15:0]             code
);
    logic [16:0] num;
    logic [16:0] den;
    logic [31:0] prod;
    logic [31:0] quot;

    // Fault first, then range clamps, then linear map
    always_comb
    begin
        num  = 17'({value[15], value} - {rangeLo[15], rangeLo});
        den  = 17'({rangeHi[15], rangeHi} - {rangeLo[15], rangeLo});
        prod = 32'(num) * 32'(lao_pkg::UA_SPAN);
        quot = (den == 17'h0_0000) ? 32'h0000_0000 : prod / 32'(den);
        if (fault)
        begin
            case (mode)
                lao_pkg::LAO_FM_HOLD: code = held;
                lao_pkg::LAO_FM_ZERO: code = lao_pkg::UA_ZERO;
                default:              code = lao_pkg::UA_4MA;
            endcase
        end
        else if (value <= rangeLo)
            code = lao_pkg::UA_4MA;
        else if (value >= rangeHi)
            code = lao_pkg::UA_20MA;
        else
            code = lao_pkg::UA_4MA + quot[15:0];
    end
endmodule

// >>> lao_pkg.sv
// Shared constants and types for the level arbitration and output block
package lao_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ          = 25_000_000;
    localparam int MEAS_CYCLE_MS   = 1000;
    localparam int MEAS_CYCLE_CLKS = MEAS_CYCLE_MS * (CLK_HZ / 1000);

    // ****************************************
    // Loop currents, in microamps
    // ****************************************
    localparam logic [15:0] UA_4MA      = 16'h0FA0; // 4.00 mA
    localparam logic [15:0] UA_20MA     = 16'h4E20; // 20.00 mA
    localparam logic [15:0] UA_SPAN     = 16'h3E80; // 16.00 mA
    localparam logic [15:0] UA_FAULT_HI = 16'h5208; // 21.0 mA
    localparam logic [15:0] UA_PRIM_HI  = 16'h4D58; // 19.8 mA
    localparam logic [15:0] UA_SEC_HI   = 16'h4E20; // 20.0 mA
    localparam logic [15:0] UA_ZERO     = 16'h0000;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_MINVALID = 8'h04;
    localparam logic [7:0] ADDR_LOW1     = 8'h08;
    localparam logic [7:0] ADDR_HIGH1    = 8'h0C;
    localparam logic [7:0] ADDR_LOW2     = 8'h10;
    localparam logic [7:0] ADDR_HIGH2    = 8'h14;
    localparam logic [7:0] ADDR_STATUS   = 8'h18;
    localparam logic [7:0] ADDR_MASK     = 8'h1C;
    localparam logic [7:0] ADDR_LEVEL    = 8'h20;
    localparam logic [7:0] ADDR_FMODE    = 8'h24;
    localparam logic [7:0] ADDR_RANGE    = 8'h40;
    localparam logic [7:0] RANGE_STRIDE  = 8'h08;
    localparam logic [7:0] RANGE_HI_OFS  = 8'h04;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_MEASURE = 0;
    localparam int CTRL_DUAL    = 1;
    localparam int ST_FLT1      = 0;
    localparam int ST_FLT2      = 1;
    localparam int ST_NOLEVEL   = 2;
    localparam int ST_CYCLE     = 3;
    localparam int ST_W         = 4;
    localparam int LEVEL_VALID  = 16;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [1:0]  RST_CTRL     = 2'h0;
    localparam logic [15:0] RST_MINVALID = 16'h0E10; // 3.6 mA
    localparam logic [15:0] RST_LOW      = 16'h0000;
    localparam logic [15:0] RST_HIGH     = 16'h03E8;
    localparam logic [15:0] RST_RANGE_HI = 16'h2710;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {LAO_FM_LOW, LAO_FM_HOLD, LAO_FM_ZERO}
        lao_fmode_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lao_bus_t;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] elev;
    } lao_lvl_t;

endpackage
